/* hdl/clkgen_pkg.sv */
// Constants shared by the two-phase clock generator files.
// Assumes a single system clock; all slower rates are enable pulses.
package clkgen_pkg;
	localparam int unsigned SYS_CLK_HZ = 20_000_000;
	localparam int unsigned SYS_CLK_PERIOD_NS = 50;
	// One state time spans this many internal clock periods
	localparam int unsigned PERIODS_PER_STATE = 2;
	// Example from the timing table: 8 MHz internal gives a 250 ns state
	localparam int unsigned EXAMPLE_F_HZ = 8_000_000;
	localparam int unsigned EXAMPLE_STATE_NS = 250;
	localparam int unsigned EXAMPLE_STATE_CYCLES =
		(EXAMPLE_STATE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	// Gap between phases, in system clock cycles
	localparam int unsigned PHASE_GAP_CYCLES = 1;
	// Values after reset
	localparam logic RST_PHASE = 1'h0;
	localparam logic RST_CLOCK_OUTPUT = 1'h0;
	localparam logic RST_GATE_RUN = 1'h1;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_ONE,
		PH_TWO
	} phase_state_t;
endpackage

/* hdl/phase_gate.sv */
// Stoppable copy of the two phase clocks for one clock group.
// Assumes phase inputs come from flip-flops of the same sys_clk_i domain.
module phase_gate
	import clkgen_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic stop_i,
	input wire logic first_phase_i,
	input wire logic second_phase_i,
	output logic first_phase_o,
	output logic second_phase_o
);
	logic run_r;
	logic run_nxt;
	logic both_low_w;

	// Gate only changes while both phases are low, so no phase is truncated
	assign both_low_w = !first_phase_i && !second_phase_i;
	assign run_nxt = both_low_w ? !stop_i : run_r;

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run_r <= RST_GATE_RUN;
			first_phase_o <= RST_PHASE;
			second_phase_o <= RST_PHASE;
		end else begin
			run_r <= run_nxt;
			first_phase_o <= first_phase_i && run_nxt;
			second_phase_o <= second_phase_i && run_nxt;
		end
	end

	a_gate_stops: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		both_low_w && stop_i ##1 !both_low_w |=> !first_phase_o && !second_phase_o)
		else $error("stopped group still sees a phase");
endmodule

/* hdl/two_phase_clock_generator.sv */
// Two-phase clock generator: doubler or direct path, phase pair, clock output.
// Assumes oscillator_input_i is sampled on sys_clk_i and that internal
// clock edges are at least two system cycles apart.
// Limitation: sampling caps the usable input rate at half of sys_clk_i direct and at a quarter when doubled.
// Stops wait for a phase gap, trading one phase of latency for whole phases.
module two_phase_clock_generator
	import clkgen_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic oscillator_input_i,
	input wire logic clock_doubler_select_i,
	input wire logic cpu_stop_i,
	input wire logic periph_stop_i,
	output logic first_phase_clock_o,
	output logic second_phase_clock_o,
	output logic clock_output_o,
	output logic clock_output_pin_o,
	output logic state_strobe_o,
	output logic cpu_first_phase_o,
	output logic cpu_second_phase_o,
	output logic periph_first_phase_o,
	output logic periph_second_phase_o
);
	phase_state_t state_r;
	phase_state_t state_nxt;
	logic osc_prev_r;
	logic osc_primed_r;
	logic first_seen_r;
	logic first_phase_r;
	logic second_phase_r;
	logic clock_output_r;
	logic clock_pin_r;
	logic state_strobe_r;
	logic osc_rise_w;
	logic osc_fall_w;
	logic tick_w;
	logic first_phase_nxt;
	logic second_phase_nxt;
	logic first_rise_w;
	logic second_rise_w;
	logic clock_output_nxt;
	logic state_strobe_nxt;

	// Internal frequency f as a one-cycle enable per internal clock edge
	// The first cycle after reset only captures the pin, so a high level is no edge
	assign osc_rise_w = osc_primed_r && oscillator_input_i && !osc_prev_r;
	assign osc_fall_w = osc_primed_r && !oscillator_input_i && osc_prev_r;
	assign tick_w = osc_rise_w || (clock_doubler_select_i && osc_fall_w);

	// Divide-by-two stage: each f tick advances to the other phase, the first tick from idle to the first phase
	always_comb begin
		state_nxt = state_r;
		if (tick_w) begin
			case (state_r)
				PH_IDLE: state_nxt = PH_ONE;
				PH_ONE: state_nxt = PH_TWO;
				PH_TWO: state_nxt = PH_ONE;
				default: state_nxt = PH_IDLE;
			endcase
		end
	end

	// A tick forces both low for one cycle, which is the non-overlap gap
	assign first_phase_nxt = (state_r == PH_ONE) && !tick_w;
	assign second_phase_nxt = (state_r == PH_TWO) && !tick_w;
	assign first_rise_w = first_phase_nxt && !first_phase_r;
	assign second_rise_w = second_phase_nxt && !second_phase_r;
	assign clock_output_nxt = first_rise_w ? 1'h1 :
		(second_rise_w ? 1'h0 : clock_output_r);
	// Strobe marks each state boundary; the first state after reset has none
	assign state_strobe_nxt = tick_w && (state_r == PH_TWO);

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r <= PH_IDLE;
			osc_prev_r <= 1'h0;
			osc_primed_r <= 1'h0;
			first_phase_r <= RST_PHASE;
			second_phase_r <= RST_PHASE;
			clock_output_r <= RST_CLOCK_OUTPUT;
			clock_pin_r <= RST_CLOCK_OUTPUT;
			state_strobe_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			osc_prev_r <= oscillator_input_i;
			osc_primed_r <= 1'h1;
			first_phase_r <= first_phase_nxt;
			second_phase_r <= second_phase_nxt;
			clock_output_r <= clock_output_nxt;
			clock_pin_r <= clock_output_r;
			state_strobe_r <= state_strobe_nxt;
		end
	end

	// All outputs come straight from flip-flops, so none can glitch
	assign first_phase_clock_o = first_phase_r;
	assign second_phase_clock_o = second_phase_r;
	assign clock_output_o = clock_output_r;
	assign clock_output_pin_o = clock_pin_r;
	assign state_strobe_o = state_strobe_r;

	// Separate gates so each group stops on its own for power saving
	phase_gate cpu_gate (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.stop_i(cpu_stop_i),
		.first_phase_i(first_phase_r),
		.second_phase_i(second_phase_r),
		.first_phase_o(cpu_first_phase_o),
		.second_phase_o(cpu_second_phase_o)
	);

	phase_gate periph_gate (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.stop_i(periph_stop_i),
		.first_phase_i(first_phase_r),
		.second_phase_i(second_phase_r),
		.first_phase_o(periph_first_phase_o),
		.second_phase_o(periph_second_phase_o)
	);

	// Check helper: remembers that a first phase has been seen since reset
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			first_seen_r <= 1'h0;
		end else begin
			first_seen_r <= first_seen_r || first_phase_r;
		end
	end

	// Checks below rely on internal clock edges at least two cycles apart
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	a_direct_ignores_fall: assert property (
		!clock_doubler_select_i && osc_prev_r && !oscillator_input_i |=> $stable(state_r))
		else $error("direct path advanced on a falling input edge");

	a_doubler_both_edges: assert property (
		clock_doubler_select_i && osc_prev_r && !oscillator_input_i && state_r != PH_IDLE
		|=> state_r != $past(state_r))
		else $error("doubler path missed a falling input edge");

	a_phase_no_overlap: assert property (
		!(first_phase_r && second_phase_r))
		else $error("phase clocks overlap");

	a_phase_gap_low: assert property (
		$rose(second_phase_r) || $rose(first_phase_r) |-> $past(!first_phase_r && !second_phase_r))
		else $error("phase started without a low gap");

	a_clock_output_edges: assert property (
		($rose(first_phase_r) |-> $rose(clock_output_r)) and
		($rose(second_phase_r) |-> $fell(clock_output_r)))
		else $error("clock output not tied to phase rising edges");

	a_pin_lags: assert property (
		##1 clock_output_pin_o == $past(clock_output_r))
		else $error("clock output pin is not the delayed internal copy");

	a_state_start: assert property (
		state_strobe_r && !tick_w |=> first_phase_r && !second_phase_r)
		else $error("state did not start with the first phase");

	a_idle_low: assert property (
		state_r == PH_IDLE |-> !first_phase_r && !second_phase_r && !clock_output_r)
		else $error("phases active before the first internal clock edge");

	a_release_quiet: assert property (
		!osc_primed_r |=> state_r == PH_IDLE)
		else $error("input level at reset release taken as an edge");

	a_first_leads: assert property (
		$rose(second_phase_r) |-> first_seen_r)
		else $error("second phase came before any first phase");

	a_strobe_before_first: assert property (
		$rose(first_phase_r) && first_seen_r |-> $past(state_strobe_r))
		else $error("state began without a state strobe");

	a_strobe_pulse: assert property (
		state_strobe_r |=> !state_strobe_r)
		else $error("state strobe longer than one cycle");

	a_clock_output_quiet: assert property (
		!$rose(first_phase_r) && !$rose(second_phase_r) |-> $stable(clock_output_r))
		else $error("clock output moved away from a phase rising edge");

	a_cpu_follows: assert property (
		(cpu_first_phase_o |-> $past(first_phase_r)) and
		(cpu_second_phase_o |-> $past(second_phase_r)))
		else $error("cpu phase high without its source phase");

	a_periph_follows: assert property (
		(periph_first_phase_o |-> $past(first_phase_r)) and
		(periph_second_phase_o |-> $past(second_phase_r)))
		else $error("peripheral phase high without its source phase");

	// Main scenarios: both paths, each group stopped alone, start after reset

	c_direct_state: cover property (
		!clock_doubler_select_i && state_strobe_r);
	c_doubled_state: cover property (
		clock_doubler_select_i && state_strobe_r);
	c_cpu_stopped: cover property (
		cpu_stop_i && first_phase_r && !cpu_first_phase_o && periph_first_phase_o);
	c_periph_stopped: cover property (
		periph_stop_i && second_phase_r && !periph_second_phase_o && cpu_second_phase_o);
	c_reset_start: cover property (
		$rose(first_phase_r) && !first_seen_r);
endmodule

/* dv/osc_source.sv */
// Oscillator source model that drives the oscillator input of the block.
// Assumes one sys_clk_i domain; its level changes only after a falling edge.
module osc_source (
	input wire logic sys_clk_i,
	input wire logic run_i,
	input wire logic [3:0] half_i,
	output logic osc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r;
	initial begin
		osc_o = 1'b0;
		cnt_r = 4'h0;
	end
	// Stands still while stopped, so no stray edge reaches the block
	always @(negedge sys_clk_i) begin
		if (run_i) begin
			cnt_r <= (cnt_r + 4'h1 >= half_i) ? 4'h0 : cnt_r + 4'h1;
			if (cnt_r + 4'h1 >= half_i) osc_o <= ~osc_o;
		end
	end
endmodule

/* dv/tb.sv */
// Self-checking bench for the two-phase clock generator.
// Assumes the osc_source model; half period 3 keeps edges 3 cycles apart.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import clkgen_pkg::*;
	logic clk, rst_b, osc, dbl, cstop, pstop, run, fp, sp, co, pin, stb, cf, cs, pf, ps;
	logic co_prev;
	int errors, compares, cycles;
	osc_source osc_source_inst (.sys_clk_i(clk), .run_i(run), .half_i(4'h3), .osc_o(osc));
	two_phase_clock_generator two_phase_clock_generator_inst (.sys_clk_i(clk),
		.rst_b_i(rst_b), .oscillator_input_i(osc), .clock_doubler_select_i(dbl),
		.cpu_stop_i(cstop), .periph_stop_i(pstop), .first_phase_clock_o(fp),
		.second_phase_clock_o(sp), .clock_output_o(co), .clock_output_pin_o(pin),
		.state_strobe_o(stb), .cpu_first_phase_o(cf), .cpu_second_phase_o(cs),
		.periph_first_phase_o(pf), .periph_second_phase_o(ps));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Counts cycles and state strobes up to the next first-phase rise, bounded
	task automatic wait_rise(output int n, output int s);
		logic prev;
		n = 0;
		s = 0;
		do begin
			prev = fp;
			@(negedge clk);
			n++;
			s += int'(stb === 1'b1);
		end while (!(fp === 1'b1 && prev === 1'b0) && n < 100);
	endtask
	task automatic t_period(input logic mode, input int exp);
		int n, s;
		dbl = mode;
		wait_rise(n, s);
		wait_rise(n, s);
		wait_rise(n, s);
		check("phase period", 8'(n), 8'(exp));
		check("strobes per state", 8'(s), 8'h01);
		check("output at first rise", co, 1'b1);
		while (sp !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check("output at second rise", co, 1'b0);
		$display("period test done, doubler %0d", mode);
	endtask
	task automatic t_stop(input logic c, input logic p);
		int nc, np, n, s;
		cstop = c;
		pstop = p;
		wait_rise(n, s);
		check("phase rise seen", 8'(n < 100), 8'h01);
		nc = 0;
		np = 0;
		repeat (12) begin
			@(negedge clk);
			nc += int'(cf === 1'b1 || cs === 1'b1);
			np += int'(pf === 1'b1 || ps === 1'b1);
		end
		check("cpu clock running", 8'(nc > 0), 8'(!c));
		check("periph clock running", 8'(np > 0), 8'(!p));
		$display("stop test done");
	endtask
	task automatic t_reset();
		int n;
		n = 0;
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		check("outputs in reset", 8'({fp, sp, co, pin, stb, cf, cs, pf}), 8'h00);
		check("periph second in reset", ps, 1'b0);
		rst_b = 1'b1;
		run = 1'b1;
		while (fp !== 1'b1 && sp !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check("first phase leads", 8'({fp, sp}), 8'h02);
		$display("reset test done");
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Watches every cycle; a stuck design fails the bounded waits well before the timeout
	always @(negedge clk) begin
		cycles++;
		check("overlap", 8'(fp & sp), 8'h00);
		if (rst_b === 1'b1) check("pin lag", pin, co_prev);
		co_prev = co;
		if (cycles > 3000) begin
			errors++;
			complete_run();
		end
	end
	initial begin
		{rst_b, dbl, cstop, pstop, run, co_prev} = 6'h00;
		{errors, compares, cycles} = 0;
		t_reset();
		// Input period is 6 cycles: one internal period is 6 direct or 3 doubled
		t_period(1'b0, PERIODS_PER_STATE * 6);
		t_period(1'b1, PERIODS_PER_STATE * 3);
		t_stop(1'b1, 1'b0);
		t_stop(1'b0, 1'b1);
		t_stop(1'b0, 1'b0);
		t_reset();
		t_period(1'b0, PERIODS_PER_STATE * 6);
		complete_run();
	end
endmodule
